// ### hdl/gfh_pkg.sv
// constants shared by the gate/flag host port design
package gfh_pkg;
	// word layout
	localparam int SLOT_MSB = 15;
	localparam int SLOT_LSB = 12;
	localparam int DATA_MSB = 11;
	localparam logic [3:0] CTL_TAG = 4'hF;
	localparam int UNIT_MSB = 3;
	// control word mode bit positions
	localparam int BIT_TIMING = 4;
	localparam int BIT_OE = 5;
	localparam int BIT_TRANSP = 6;
	localparam int BIT_ISL = 7;
	// unit number this device answers to
	localparam logic [3:0] UNIT_ADDR = 4'h0;
	// example words: octal 170160, 170260, 007777
	localparam logic [15:0] CW_OUTPUT_EX = 16'hF070;
	localparam logic [15:0] CW_INPUT_EX = 16'hF0B0;
	localparam logic [15:0] DW_ONES_EX = 16'h0FFF;
	// readback: request identification bit
	localparam int RET_REQ_BIT = 15;
	// handshake flag turnaround
	localparam int CLK_PERIOD_NS = 10;
	localparam int HS_FLAG_NS = 100;
	localparam logic [3:0] HS_FLAG_CYC = 4'((HS_FLAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// register byte offsets
	localparam logic [4:0] REG_STATUS = 5'h00;
	localparam logic [4:0] REG_CONTROL = 5'h04;
	localparam logic [4:0] REG_SEARCH = 5'h08;
	localparam logic [4:0] REG_READY = 5'h0C;
	localparam int CTRL_RANK_UPD = 0;
	// reset values
	localparam logic FLAG_RESET = 1'b1;
	localparam logic WAITREQ_RESET = 1'b1;
endpackage : gfh_pkg

// ### hdl/gfh_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module gfh_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// pins in, filtered level out
	input wire logic [W-1:0] pin,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} gfh_sync_t;

	gfh_sync_t st;
	gfh_sync_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// a bit changes only once stages two and three agree
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.q;
endmodule : gfh_sync
`default_nettype wire

// ### hdl/gfh_host_port.sv
// gate/flag host word port with output and input card logic
`timescale 1ns/1ns
`default_nettype none
// Contract
// - control word 170160 octal enables output, transparency, timing; selects unit zero.
// - control word 170260 octal enables output, timing, input select; selects unit zero.
// - data word 007777 octal sets all data bits of slot zero to one.
// - in input select, address word with upper field one selects input slot one.
// - output enable mode makes stored card data visible to external devices.
// - transparency makes dual-rank cards act single-rank, data appears at once.
// - transparency enables an output card's gate; otherwise that gate stays off.
// - timing mode drives the host flag from the addressed output card's flag.
// - a gate clears the flag; host waits for the flag before the next word.
// - a gated address word activates the input card, starting its acquisition.
// - in timing mode a ready activated input card sets the host flag.
// - another gate with the address still held reactivates the input card.
// - addressed input data is readable without gate after a host delay.
// - output cards act on a data word only upon the gate.
// - control words take effect only with the gate.
// - local source takes words from panel controls, behaviour depends on input select.
// - a search mode activates many input cards at once.
// - timing off in input select: own handshake flag drives the host flag.
// - readback puts data on bits 0 to 11 and ready bit on bit 15.
module gfh_host_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// host parallel lines
	input wire logic [15:0] host_word,
	input wire logic host_gate,
	output logic host_flag,
	output logic [15:0] return_data,
	// output cards
	output logic [15:0][11:0] out_card_data,
	output logic [15:0] out_card_gate,
	input wire logic [15:0] out_card_flag,
	// input cards
	input wire logic [15:0][11:0] in_card_data,
	input wire logic [15:0] in_dev_flag,
	output logic [15:0] in_card_gate,
	// front panel
	input wire logic panel_local,
	input wire logic [15:0] panel_word,
	input wire logic panel_load,
	input wire logic panel_return,
	output logic [15:0] panel_lamps,
	output logic panel_return_lamp,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef struct packed {
		logic gate_d;
		logic unit_sel;
		logic output_enable_mode;
		logic transparent_gating_mode;
		logic timing_mode;
		logic input_select_mode;
		logic [3:0] held_slot;
		logic out_wait;
		logic saw_busy;
		logic last_was_ctl;
		logic own_flag;
		logic [3:0] hs_cnt;
		logic [15:0][11:0] stage;
		logic [15:0][11:0] hold;
		logic [15:0][11:0] vis;
		logic [15:0] out_gate;
		logic [15:0] in_active;
		logic [15:0] in_gate;
		logic [15:0] in_ready;
		logic [15:0] ret;
		logic [15:0] lamps;
		logic ret_lamp;
		logic flag;
		logic waitreq;
		logic [31:0] rdata;
	} gfh_port_t;

	gfh_port_t st;
	gfh_port_t next_st;

	logic [15:0] host_word_s;
	logic host_gate_s;
	logic [15:0] out_flag_s;
	logic [15:0][11:0] in_data_s;
	logic [15:0] in_flag_s;
	logic [15:0] panel_word_s;
	logic panel_local_s;
	logic panel_load_s;
	logic panel_return_s;

	gfh_sync #(.W(17)) u_sync_host (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin({host_gate, host_word}),
		.q({host_gate_s, host_word_s})
	);
	gfh_sync #(.W(19)) u_sync_panel (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin({panel_local, panel_load, panel_return, panel_word}),
		.q({panel_local_s, panel_load_s, panel_return_s, panel_word_s})
	);
	gfh_sync #(.W(224)) u_sync_cards (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin({out_card_flag, in_dev_flag, in_card_data}),
		.q({out_flag_s, in_flag_s, in_data_s})
	);

	logic [15:0] word;
	logic gate;
	logic [3:0] slot;
	logic rank_upd;
	logic bus_req;

	always_comb begin
		next_st = st;
		word = host_word_s;
		gate = host_gate_s;
		rank_upd = 1'b0;
		// local panel replaces the host lines; with input select only address bits count
		if (panel_local_s) begin
			gate = panel_load_s;
			word = st.input_select_mode ? {panel_word_s[gfh_pkg::SLOT_MSB:gfh_pkg::SLOT_LSB], 12'h000} : panel_word_s;
		end
		// address decoding is live so data can be read without a gate
		slot = word[gfh_pkg::SLOT_MSB:gfh_pkg::SLOT_LSB];
		next_st.gate_d = gate;

		// per-card handshakes with external devices
		for (int i = 0; i < 16; i++) begin
			if (st.in_active[i] && st.in_gate[i] && !in_flag_s[i]) begin
				next_st.in_gate[i] = 1'b0;
			end
			if (st.in_active[i] && !st.in_gate[i] && in_flag_s[i]) begin
				next_st.in_active[i] = 1'b0;
				next_st.in_ready[i] = 1'b1;
			end
			if (st.out_gate[i] && !out_flag_s[i]) begin
				next_st.out_gate[i] = 1'b0;
			end
			if (!st.transparent_gating_mode) begin
				next_st.out_gate[i] = 1'b0;
			end
		end

		// timing wait ends on the card flag returning to ready after a busy phase
		if (st.out_wait) begin
			if (!out_flag_s[st.held_slot]) begin
				next_st.saw_busy = 1'b1;
			end else if (st.saw_busy) begin
				next_st.out_wait = 1'b0;
			end
		end

		// handshake flag comes back a fixed time after the word was taken
		if (st.hs_cnt != 4'h0) begin
			next_st.hs_cnt = st.hs_cnt - 4'h1;
			if (st.hs_cnt == 4'h1) begin
				next_st.own_flag = 1'b1;
			end
		end

		// avalon slave: each access answers at the second edge
		bus_req = avs_read || avs_write;
		next_st.waitreq = !(bus_req && st.waitreq);
		if (bus_req && st.waitreq) begin
			unique case (avs_address)
				gfh_pkg::REG_STATUS: begin
					next_st.rdata = {20'h0, st.flag, st.own_flag, st.out_wait, st.held_slot,
						st.input_select_mode, st.timing_mode, st.transparent_gating_mode,
						st.output_enable_mode, st.unit_sel};
				end
				gfh_pkg::REG_SEARCH: next_st.rdata = {16'h0, st.in_active};
				gfh_pkg::REG_READY: next_st.rdata = {16'h0, st.in_ready};
				default: next_st.rdata = 32'h0;
			endcase
		end
		if (avs_write && !st.waitreq) begin
			if (avs_address == gfh_pkg::REG_CONTROL) begin
				rank_upd = avs_writedata[gfh_pkg::CTRL_RANK_UPD];
			end
			// search: activate every masked input card together
			if (avs_address == gfh_pkg::REG_SEARCH && st.input_select_mode && st.unit_sel) begin
				for (int i = 0; i < 16; i++) begin
					if (avs_writedata[i]) begin
						next_st.in_active[i] = 1'b1;
						next_st.in_gate[i] = 1'b1;
						next_st.in_ready[i] = 1'b0;
					end
				end
			end
		end

		// words act only on the gate's rising edge
		if (gate && !st.gate_d) begin
			next_st.own_flag = 1'b0;
			next_st.hs_cnt = gfh_pkg::HS_FLAG_CYC;
			// no card answers a control word, so its flag is always the own handshake flag
			next_st.last_was_ctl = (word[gfh_pkg::SLOT_MSB:gfh_pkg::SLOT_LSB] == gfh_pkg::CTL_TAG);
			if (word[gfh_pkg::SLOT_MSB:gfh_pkg::SLOT_LSB] == gfh_pkg::CTL_TAG) begin
				next_st.unit_sel = (word[gfh_pkg::UNIT_MSB:0] == gfh_pkg::UNIT_ADDR);
				if (word[gfh_pkg::UNIT_MSB:0] == gfh_pkg::UNIT_ADDR) begin
					next_st.output_enable_mode = word[gfh_pkg::BIT_OE];
					next_st.transparent_gating_mode = word[gfh_pkg::BIT_TRANSP];
					next_st.timing_mode = word[gfh_pkg::BIT_TIMING];
					next_st.input_select_mode = word[gfh_pkg::BIT_ISL];
				end
				// a fresh control word also releases a hung timing wait
				next_st.out_wait = 1'b0;
				next_st.saw_busy = 1'b0;
			end else if (st.unit_sel) begin
				if (st.input_select_mode) begin
					// activation or reactivation of the addressed input card
					next_st.in_active[slot] = 1'b1;
					next_st.in_gate[slot] = 1'b1;
					next_st.in_ready[slot] = 1'b0;
				end else begin
					next_st.stage[slot] = word[gfh_pkg::DATA_MSB:0];
					next_st.held_slot = slot;
					next_st.in_active[slot] = 1'b0;
					next_st.in_gate[slot] = 1'b0;
					next_st.in_ready[slot] = 1'b0;
					if (st.transparent_gating_mode) begin
						next_st.out_gate[slot] = 1'b1;
					end
					if (st.timing_mode) begin
						next_st.out_wait = 1'b1;
						next_st.saw_busy = 1'b0;
					end
				end
			end
		end

		// second rank follows the first while transparent, or on a software update
		if (next_st.transparent_gating_mode || rank_upd) begin
			next_st.hold = next_st.stage;
		end
		next_st.vis = st.output_enable_mode ? st.hold : '0;

		// readback lines: addressed input card in input select, else the panel pattern under local source, else zero
		if (st.input_select_mode) begin
			next_st.ret = {st.in_ready[slot], 3'h0, in_data_s[slot]};
		end else if (panel_local_s) begin
			next_st.ret = panel_word_s;
		end else begin
			next_st.ret = 16'h0000;
		end

		// flag source: card logic in timing mode after a card word, own handshake flag otherwise
		if (st.timing_mode && st.input_select_mode && !st.last_was_ctl) begin
			next_st.flag = st.in_ready[slot] && !st.in_active[slot];
		end else if (st.timing_mode && !st.last_was_ctl) begin
			next_st.flag = !st.out_wait;
		end else begin
			next_st.flag = st.own_flag;
		end
		if (panel_local_s && panel_return_s) begin
			next_st.flag = 1'b1;
		end

		// panel lamps mirror the active word (panel switches or host lines), or card data in input select
		if (st.input_select_mode) begin
			next_st.lamps = {word[gfh_pkg::SLOT_MSB:gfh_pkg::SLOT_LSB], in_data_s[slot]};
			next_st.ret_lamp = panel_return_s || st.in_ready[slot];
		end else begin
			next_st.lamps = word;
			next_st.ret_lamp = st.flag;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			st <= '0;
			st.own_flag <= gfh_pkg::FLAG_RESET;
			st.flag <= gfh_pkg::FLAG_RESET;
			st.waitreq <= gfh_pkg::WAITREQ_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign host_flag = st.flag;
	assign return_data = st.ret;
	assign out_card_data = st.vis;
	assign out_card_gate = st.out_gate;
	assign in_card_gate = st.in_gate;
	assign panel_lamps = st.lamps;
	assign panel_return_lamp = st.ret_lamp;
	assign avs_readdata = st.rdata;
	assign avs_waitrequest = st.waitreq;
endmodule : gfh_host_port
`default_nettype wire

// ### sim/gfh_host_port_asserts.sv
// concurrent checks on the host port pins
`timescale 1ns/1ns
`default_nettype none
module gfh_host_port_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// host side
	input wire logic host_gate,
	input wire logic host_flag,
	input wire logic [15:0] return_data,
	// card side
	input wire logic [15:0][11:0] out_card_data,
	input wire logic [15:0] out_card_gate,
	input wire logic [15:0] in_card_gate,
	// register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// cycles since a gate edge or bus write; saturates so a quiet port never wraps
	logic gate_q;
	logic [7:0] since;
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			gate_q <= 1'b0;
			since <= 8'hFF;
		end else begin
			gate_q <= host_gate;
			if ((host_gate && !gate_q) || (avs_write && !avs_waitrequest)) since <= 8'h00;
			else if (since != 8'hFF) since <= since + 8'h01;
		end
	end
	property p_gate_clears; $rose(host_gate) |-> ##[1:10] !host_flag; endproperty
	a_gate_clears: assert property (p_gate_clears) else $error("flag not cleared after gate");
	property p_flag_cause; $fell(host_flag) |-> since <= 8'h0C; endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag fell without gate");
	property p_outgate_cause; (out_card_gate & ~$past(out_card_gate)) != 16'h0000 |-> since <= 8'h0C; endproperty
	a_outgate_cause: assert property (p_outgate_cause) else $error("output card gate without host gate");
	property p_ingate_cause; (in_card_gate & ~$past(in_card_gate)) != 16'h0000 |-> since <= 8'h0C; endproperty
	a_ingate_cause: assert property (p_ingate_cause) else $error("input card gate without host gate");
	property p_data_cause; $changed(out_card_data) |-> since <= 8'h14; endproperty
	a_data_cause: assert property (p_data_cause) else $error("output data changed without gate");
	property p_ret_id; return_data[15] |-> return_data[14:12] == 3'h0; endproperty
	a_ret_id: assert property (p_ret_id) else $error("readback bits 14 to 12 not zero");
	property p_rst_vals; $rose(rst_b) |-> host_flag && avs_waitrequest; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("wrong levels after reset");
	property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer late");
	property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
	c_in_act: cover property ($rose(in_card_gate[1]));
	c_flag_back: cover property ($rose(host_flag));
	c_bus_read: cover property (avs_read && !avs_waitrequest);
endmodule : gfh_host_port_asserts
bind gfh_host_port gfh_host_port_asserts chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .host_gate(host_gate),
	.host_flag(host_flag), .return_data(return_data), .out_card_data(out_card_data), .out_card_gate(out_card_gate),
	.in_card_gate(in_card_gate), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// ### sim/gfh_card_model.sv
// external devices behind output and input cards: busy then ready after each gate
`timescale 1ns/1ns
`default_nettype none
module gfh_card_model (
	// clock
	input wire logic sys_clk,
	// gates and response delay
	input wire logic [15:0] out_card_gate,
	input wire logic [15:0] in_card_gate,
	input wire logic [7:0] dly,
	// flags and data back
	output logic [15:0] out_card_flag,
	output logic [15:0] in_dev_flag,
	output logic [15:0][11:0] in_card_data
);
	wire logic [31:0] g = {in_card_gate, out_card_gate};
	logic [31:0] gq = '0;
	logic [31:0][8:0] cnt = '0;
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < 32; i++) begin
			gq[i] <= g[i];
			if (g[i] && !gq[i]) cnt[i] <= {dly, 1'b0};
			else if (cnt[i] != 9'h000) cnt[i] <= cnt[i] - 9'h001;
		end
	end
	// data is inverted while busy so a premature read cannot match
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			out_card_flag[i] = !(cnt[i] != 9'h000 && cnt[i] <= {1'b0, dly});
			in_dev_flag[i] = !(cnt[i+16] != 9'h000 && cnt[i+16] <= {1'b0, dly});
			in_card_data[i] = in_dev_flag[i] ? (12'hA50 | 12'(i)) : ~(12'hA50 | 12'(i));
		end
	end
endmodule : gfh_card_model
`default_nettype wire

// ### sim/gfh_host_port_tb_top.sv
// self-checking bench for the gate/flag host port
`timescale 1ns/1ns
`default_nettype none
module gfh_host_port_tb_top;
	logic sys_clk, rst_b, host_gate, host_flag, avs_read, avs_write, avs_waitrequest, panel_return_lamp;
	logic [15:0] host_word, return_data, out_card_gate, out_card_flag, in_dev_flag, in_card_gate, panel_lamps;
	logic [15:0][11:0] out_card_data, in_card_data;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [7:0] dly;
	logic panel_local, panel_load, panel_return;
	logic [15:0] panel_word;
	int failures, tests_run, cycles, cyc, n_out0, n_in1, k;
	gfh_host_port dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .host_word(host_word), .host_gate(host_gate),
		.host_flag(host_flag), .return_data(return_data), .out_card_data(out_card_data), .out_card_gate(out_card_gate),
		.out_card_flag(out_card_flag), .in_card_data(in_card_data), .in_dev_flag(in_dev_flag),
		.in_card_gate(in_card_gate), .panel_local(panel_local), .panel_word(panel_word), .panel_load(panel_load),
		.panel_return(panel_return), .panel_lamps(panel_lamps), .panel_return_lamp(panel_return_lamp),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	gfh_card_model card_u (.sys_clk(sys_clk), .out_card_gate(out_card_gate), .in_card_gate(in_card_gate),
		.dly(dly), .out_card_flag(out_card_flag), .in_dev_flag(in_dev_flag), .in_card_data(in_card_data));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task summarize();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	// counts gate rises so scenarios can compare before and after
	logic [15:0] og_q = '0, ig_q = '0;
	always @(posedge sys_clk) begin
		og_q <= out_card_gate;
		ig_q <= in_card_gate;
		if (out_card_gate[0] && !og_q[0]) n_out0 <= n_out0 + 1;
		if (in_card_gate[1] && !ig_q[1]) n_in1 <= n_in1 + 1;
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures = failures + 1;
			summarize();
		end
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task av(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		// no limit of its own: if waitrequest stays high only the bench timeout ends this wait
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	// settle, gate, expect the flag to drop, then wait for ready, or check it stays low when a hang is expected
	task host_send(input logic [15:0] w, input logic hang);
		@(posedge sys_clk);
		host_word <= w;
		repeat (800) @(posedge sys_clk);
		host_gate <= 1'b1;
		cyc = 0;
		while (host_flag !== 1'b0 && cyc < 50) begin
			@(posedge sys_clk);
			cyc++;
		end
		chk("flag dropped by gate", 32'h0, {31'h0, host_flag});
		while (host_flag !== 1'b1 && cyc < 2000) begin
			@(posedge sys_clk);
			cyc++;
		end
		chk("flag ready", {31'h0, !hang}, {31'h0, host_flag});
		host_gate <= 1'b0;
		repeat (10) @(posedge sys_clk);
	endtask : host_send
	task present(input logic [15:0] w);
		@(posedge sys_clk);
		host_word <= w;
		repeat (20) @(posedge sys_clk);
	endtask : present
	task modes(input logic [31:0] exp);
		av(1'b0, gfh_pkg::REG_STATUS, 32'h0, d);
		chk("mode bits", exp, d & 32'h0000001F);
	endtask : modes
	task t_output();
		present(gfh_pkg::CW_OUTPUT_EX);
		modes(32'h00000000);
		host_send(16'hF030, 1'b0);
		k = n_out0;
		host_send(16'h0555, 1'b1);
		chk("gate with transparency off", k, n_out0);
		chk("dual rank holds", 32'h0, {20'h0, out_card_data[0]});
		host_send(gfh_pkg::CW_OUTPUT_EX, 1'b0);
		modes(32'h0000000F);
		chk("first rank shown", 32'h00000555, {20'h0, out_card_data[0]});
		present(16'h0123);
		chk("ungated data ignored", 32'h00000555, {20'h0, out_card_data[0]});
		dly <= 8'h1E;
		host_send(gfh_pkg::DW_ONES_EX, 1'b0);
		chk("timing flag wait", 32'h1, {31'h0, cyc > 60});
		chk("card gate", k + 1, n_out0);
		chk("slot zero data", 32'h00000FFF, {20'h0, out_card_data[0]});
	endtask : t_output
	task t_input();
		host_send(gfh_pkg::CW_INPUT_EX, 1'b0);
		modes(32'h0000001B);
		k = n_in1;
		host_send(16'h1ABC, 1'b0);
		chk("slot one activated", k + 1, n_in1);
		chk("input ready flag wait", 32'h1, {31'h0, cyc > 60});
		repeat (1200) @(posedge sys_clk);
		chk("readback", 32'h00008A51, {16'h0, return_data});
		host_send(16'h1ABC, 1'b0);
		chk("reactivated", k + 2, n_in1);
		av(1'b1, gfh_pkg::REG_SEARCH, 32'h00000004, d);
		av(1'b0, gfh_pkg::REG_SEARCH, 32'h0, d);
		chk("search active", 32'h00000004, d & 32'h00000004);
	endtask : t_input
	// local source with input select: lamps show the card addressed from the panel
	task t_panel();
		@(posedge sys_clk);
		panel_word <= 16'h1000;
		panel_local <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk("panel lamps", 32'h00001A51, {16'h0, panel_lamps});
		chk("panel return lamp", 32'h1, {31'h0, panel_return_lamp});
		chk("panel readback", 32'h00008A51, {16'h0, return_data});
	endtask : t_panel
	initial begin
		rst_b = 1'b0;
		host_gate = 1'b0;
		host_word = 16'h0000;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		dly = 8'h04;
		panel_local = 1'b0;
		panel_load = 1'b0;
		panel_return = 1'b0;
		panel_word = 16'h0000;
		failures = 0;
		tests_run = 0;
		cycles = 0;
		n_out0 = 0;
		n_in1 = 0;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		chk("flag after reset", 32'h1, {31'h0, host_flag});
		av(1'b0, 5'h10, 32'h0, d);
		chk("unmapped read", 32'h0, d);
		t_output();
		t_input();
		t_panel();
		summarize();
	end
endmodule : gfh_host_port_tb_top
`default_nettype wire
